// [core/ivm_defines.vh]
// Constants for the interrupt vector mapper: slot addresses, masks, resets
`ifndef IVM_DEFINES_VH
`define IVM_DEFINES_VH

// ----------------------------------------------------------------
// Table geometry
// ----------------------------------------------------------------
`define IVM_ADDR_W 5
`define IVM_NSLOT 26

// ----------------------------------------------------------------
// Vector word addresses (slot index equals word address)
// ----------------------------------------------------------------
`define IVM_ADDR_RESET 5'h00
`define IVM_ADDR_NMI 5'h01
`define IVM_ADDR_VLM 5'h02
`define IVM_ADDR_PORT1 5'h03
`define IVM_ADDR_PORT2 5'h04
`define IVM_ADDR_PORT3 5'h05
`define IVM_ADDR_RTC_COUNT 5'h06
`define IVM_ADDR_RTC_TICK 5'h07
`define IVM_ADDR_TA_OVF 5'h08
`define IVM_ADDR_TA_HIGH 5'h09
`define IVM_ADDR_TA_CMP0 5'h0a
`define IVM_ADDR_TB_CAPT 5'h0d
`define IVM_ADDR_GAP_A 5'h0e
`define IVM_ADDR_GAP_B 5'h0f
`define IVM_ADDR_COMP 5'h10
`define IVM_ADDR_ADC_RES 5'h11
`define IVM_ADDR_ADC_WIN 5'h12
`define IVM_ADDR_TW_CLIENT 5'h13
`define IVM_ADDR_TW_HOST 5'h14
`define IVM_ADDR_SPI 5'h15
`define IVM_ADDR_SER_RX 5'h16
`define IVM_ADDR_SER_EMPTY 5'h17
`define IVM_ADDR_SER_TX 5'h18
`define IVM_ADDR_EE_READY 5'h19

// ----------------------------------------------------------------
// Slots that hold a source; gaps at 0x00, 0x0e and 0x0f
// ----------------------------------------------------------------
`define IVM_SLOT_MASK 26'h3ff3ffe

// ----------------------------------------------------------------
// Pin-count thresholds for the optional ports
// ----------------------------------------------------------------
`define IVM_PINS_PORT2 14
`define IVM_PINS_PORT3 20

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IVM_RST_FLAG 1'h0
`define IVM_RST_FLAGS 26'h0000000

`endif

// [core/ivm_source.v]
// One interrupt source: sticky pending flag gated by its enable bit
`timescale 1ns/1ps
`include "ivm_defines.vh"

module ivm_source (
	input wire mclk,
	input wire sys_rst,
	input wire set_event,
	input wire clear_flag,
	input wire enable,
	output reg flag,
	output wire request
);

	// Sticky flag; a set in the clearing cycle wins
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			flag <= `IVM_RST_FLAG;
		end else if (set_event) begin
			flag <= 1'h1;
		end else if (clear_flag) begin
			flag <= 1'h0;
		end
	end

	// Request while flag and enable both stand
	assign request = flag & enable;

endmodule // ivm_source

// [core/ivm_priority.v]
// Lowest-index-first priority encoder over the vector slots
`timescale 1ns/1ps
`include "ivm_defines.vh"

module ivm_priority (
	input wire [`IVM_NSLOT-1:0] req,
	output reg valid,
	output reg [`IVM_ADDR_W-1:0] index
);

	integer i;

	// Scan from top down so the lowest set slot is kept last
	always @* begin
		valid = 1'h0;
		index = `IVM_ADDR_RESET;
		for (i = `IVM_NSLOT - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				valid = 1'h1;
				index = i[`IVM_ADDR_W-1:0];
			end
		end
	end

endmodule // ivm_priority

// [core/ivm_mapper.v]
// Interrupt request generation and vector mapping toward the core
`timescale 1ns/1ps
`include "ivm_defines.vh"

module ivm_mapper #(
	parameter PIN_COUNT = 20
) (
	input wire mclk,
	input wire sys_rst,
	input wire global_enable,
	input wire timer_a_split,
	input wire [`IVM_NSLOT-1:0] irq_control_register,
	input wire [`IVM_NSLOT-1:0] flag_clear,
	input wire memscan_error_event,
	input wire voltage_monitor_event,
	input wire port_first_event,
	input wire port_second_event,
	input wire port_third_event,
	input wire rtc_count_event,
	input wire periodic_tick_event,
	input wire timer_a_overflow_event,
	input wire timer_a_low_underflow_event,
	input wire timer_a_high_underflow_event,
	input wire [2:0] timer_a_compare_event,
	input wire [2:0] timer_a_low_compare_event,
	input wire timer_b_capture_event,
	input wire comparator_event,
	input wire converter_result_event,
	input wire converter_window_event,
	input wire twowire_client_event,
	input wire twowire_host_event,
	input wire serial_periph_event,
	input wire serial_rx_complete_event,
	input wire serial_data_empty_event,
	input wire serial_tx_complete_event,
	input wire eeprom_ready_event,
	output wire [`IVM_NSLOT-1:0] pending_flag_register,
	output reg [`IVM_NSLOT-1:0] active_requests,
	output reg irq_request,
	output reg nmi_request,
	output reg [`IVM_ADDR_W-1:0] irq_vector_addr
);

	// ----------------------------------------------------------------
	// Slot existence
	// ----------------------------------------------------------------

	wire port2_present;
	wire port3_present;
	wire [`IVM_NSLOT-1:0] slot_exist;

	// Optional port vectors depend on the package pin count
	assign port2_present = (PIN_COUNT >= `IVM_PINS_PORT2);
	assign port3_present = (PIN_COUNT >= `IVM_PINS_PORT3);

	// Drop absent port slots from the fixed slot mask
	assign slot_exist = `IVM_SLOT_MASK
		& ~({{(`IVM_NSLOT-1){1'h0}}, ~port2_present} << `IVM_ADDR_PORT2)
		& ~({{(`IVM_NSLOT-1){1'h0}}, ~port3_present} << `IVM_ADDR_PORT3);

	// ----------------------------------------------------------------
	// Event routing to vector slots
	// ----------------------------------------------------------------

	wire [`IVM_NSLOT-1:0] slot_event;

	// Reset slot has no flag; the gap slots carry nothing
	assign slot_event[`IVM_ADDR_RESET] = 1'h0;
	assign slot_event[`IVM_ADDR_GAP_A] = 1'h0;
	assign slot_event[`IVM_ADDR_GAP_B] = 1'h0;

	// Non-maskable memory scan fault
	assign slot_event[`IVM_ADDR_NMI] = memscan_error_event;

	// Supply monitor and the three ports
	assign slot_event[`IVM_ADDR_VLM] = voltage_monitor_event;
	assign slot_event[`IVM_ADDR_PORT1] = port_first_event;
	assign slot_event[`IVM_ADDR_PORT2] = port_second_event;
	assign slot_event[`IVM_ADDR_PORT3] = port_third_event;

	// Real-time counter has two vectors of its own
	assign slot_event[`IVM_ADDR_RTC_COUNT] = rtc_count_event;
	assign slot_event[`IVM_ADDR_RTC_TICK] = periodic_tick_event;

	// Split mode routes the low-half condition onto a shared slot
	function ta_pick;
		input split;
		input normal_event;
		input split_event;
		begin
			ta_pick = split ? split_event : normal_event;
		end
	endfunction

	// Timer A: mode picks which condition feeds the shared vectors
	assign slot_event[`IVM_ADDR_TA_OVF] = ta_pick(timer_a_split,
		timer_a_overflow_event, timer_a_low_underflow_event);
	assign slot_event[`IVM_ADDR_TA_HIGH] =
		timer_a_split & timer_a_high_underflow_event;

	// Timer A compare channels, full or low byte by mode
	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_cmp
			assign slot_event[`IVM_ADDR_TA_CMP0 + k] = ta_pick(timer_a_split,
				timer_a_compare_event[k],
				timer_a_low_compare_event[k]);
		end
	endgenerate

	// Timer B capture
	assign slot_event[`IVM_ADDR_TB_CAPT] = timer_b_capture_event;

	// Analog comparator and converter
	assign slot_event[`IVM_ADDR_COMP] = comparator_event;
	assign slot_event[`IVM_ADDR_ADC_RES] = converter_result_event;
	assign slot_event[`IVM_ADDR_ADC_WIN] = converter_window_event;

	// Two-wire and serial peripheral interface
	assign slot_event[`IVM_ADDR_TW_CLIENT] = twowire_client_event;
	assign slot_event[`IVM_ADDR_TW_HOST] = twowire_host_event;
	assign slot_event[`IVM_ADDR_SPI] = serial_periph_event;

	// Serial transceiver, three vectors
	assign slot_event[`IVM_ADDR_SER_RX] = serial_rx_complete_event;
	assign slot_event[`IVM_ADDR_SER_EMPTY] =
		serial_data_empty_event;
	assign slot_event[`IVM_ADDR_SER_TX] = serial_tx_complete_event;

	// Nonvolatile memory ready
	assign slot_event[`IVM_ADDR_EE_READY] = eeprom_ready_event;

	// ----------------------------------------------------------------
	// Pending flags and per-source gating
	// ----------------------------------------------------------------

	wire [`IVM_NSLOT-1:0] slot_request;

	// One flag cell per slot in the fixed slot mask; absent slots read as zero
	genvar i;
	generate
		for (i = 0; i < `IVM_NSLOT; i = i + 1) begin : g_src
			if (((`IVM_SLOT_MASK >> i) & 1) != 0) begin : g_cell
				wire cell_flag;
				wire cell_req;
				wire cell_en;
				// NMI slot ignores the software enable bit
				assign cell_en = (i == `IVM_ADDR_NMI) ? 1'h1 :
					irq_control_register[i];
				ivm_source u_src (
					.mclk(mclk),
					.sys_rst(sys_rst),
					.set_event(slot_event[i] & slot_exist[i]),
					.clear_flag(flag_clear[i]),
					.enable(cell_en),
					.flag(cell_flag),
					.request(cell_req)
				);
				assign pending_flag_register[i] = cell_flag & slot_exist[i];
				assign slot_request[i] = cell_req & slot_exist[i];
			end else begin : g_none
				assign pending_flag_register[i] = 1'h0;
				assign slot_request[i] = 1'h0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Global gating and priority
	// ----------------------------------------------------------------

	wire [`IVM_NSLOT-1:0] nmi_bit;
	wire [`IVM_NSLOT-1:0] deliver;
	wire pick_valid;
	wire [`IVM_ADDR_W-1:0] pick_index;

	assign nmi_bit = {{(`IVM_NSLOT-1){1'h0}}, 1'h1} << `IVM_ADDR_NMI;

	// Maskable slots need global enable; NMI passes regardless
	assign deliver = (slot_request & ~nmi_bit & {`IVM_NSLOT{global_enable}})
		| (slot_request & nmi_bit);

	// Lowest vector number wins
	ivm_priority u_prio (
		.req(deliver),
		.valid(pick_valid),
		.index(pick_index)
	);

	// ----------------------------------------------------------------
	// Registered outputs to the core
	// ----------------------------------------------------------------

	// Request and address held while any delivered request stands
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_request <= 1'b0;
			nmi_request <= 1'b0;
			irq_vector_addr <= `IVM_ADDR_RESET;
			active_requests <= `IVM_RST_FLAGS;
		end else begin
			irq_request <= pick_valid;
			nmi_request <= |(deliver & nmi_bit);
			irq_vector_addr <= pick_valid ? pick_index :
				`IVM_ADDR_RESET;
			active_requests <= deliver;
		end
	end

endmodule // ivm_mapper

// [dv/ivm_core_model.sv]
// Core model that services delivered vectors by clearing their flags
`timescale 1ns/1ps

module ivm_core_model #(
	parameter DELAY = 3
) (
	input wire mclk,
	input wire sys_rst,
	input wire serve,
	input wire irq_request,
	input wire [4:0] irq_vector_addr,
	output reg [25:0] svc_clear,
	output reg [4:0] last_addr
);
	reg [3:0] wait_cnt;

	// Service routine: clears the fetched slot after DELAY cycles
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			svc_clear <= 26'h0;
			last_addr <= 5'h00;
			wait_cnt <= 4'h0;
		end else begin
			svc_clear <= 26'h0;
			wait_cnt <= 4'h0;
			if (serve && irq_request && wait_cnt != DELAY)
				wait_cnt <= wait_cnt + 4'h1;
			else if (serve && irq_request) begin
				svc_clear <= 26'h1 << irq_vector_addr;
				last_addr <= irq_vector_addr;
			end
		end
	end
endmodule // ivm_core_model

// [dv/ivm_mapper_monitor.sv]
// Port checker for the interrupt vector mapper
`timescale 1ns/1ps

module ivm_mapper_monitor #(
	parameter PIN_COUNT = 20
) (
	input wire mclk,
	input wire sys_rst,
	input wire global_enable,
	input wire [25:0] irq_control_register,
	input wire [25:0] flag_clear,
	input wire voltage_monitor_event,
	input wire [25:0] pending_flag_register,
	input wire [25:0] active_requests,
	input wire irq_request,
	input wire nmi_request,
	input wire [4:0] irq_vector_addr
);
	localparam [25:0] MASK = 26'h3ff3ffc;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// Lowest maskable slot that is set
	function [4:0] lowest(input [25:0] v);
		integer k;
		begin
			lowest = 5'h00;
			for (k = 25; k >= 2; k = k - 1)
				if (v[k]) lowest = k[4:0];
		end
	endfunction

	property p_act;
		(active_requests & MASK) == $past(pending_flag_register
			& irq_control_register & {26{global_enable}} & MASK);
	endproperty
	a_act: assert property (p_act) else $error("bad act");
	property p_nmi;
		nmi_request == $past(pending_flag_register[1]);
	endproperty
	a_nmi: assert property (p_nmi) else $error("bad nmi");
	property p_irq;
		|active_requests[25:2] |-> irq_request;
	endproperty
	a_irq: assert property (p_irq) else $error("bad irq");
	property p_low;
		irq_request && !nmi_request |->
			irq_vector_addr == lowest(active_requests);
	endproperty
	a_low: assert property (p_low) else $error("bad order");
	property p_idle;
		!irq_request && !nmi_request |-> irq_vector_addr == 5'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("bad idle");
	property p_hold;
		($past(pending_flag_register & ~flag_clear)
			& ~pending_flag_register) == 26'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("bad hold");
	property p_vlm;
		voltage_monitor_event |=> pending_flag_register[2];
	endproperty
	a_vlm: assert property (p_vlm) else $error("bad set");
	property p_clr;
		flag_clear[2] && !voltage_monitor_event |=> !pending_flag_register[2];
	endproperty
	a_clr: assert property (p_clr) else $error("bad clear");
	property p_port;
		PIN_COUNT < 20 |-> !pending_flag_register[5];
	endproperty
	a_port: assert property (p_port) else $error("bad port");
endmodule // ivm_mapper_monitor

// [dv/tb_top.sv]
// Self-checking bench for the interrupt vector mapper
`timescale 1ns/1ps

module tb_top;
	reg mclk = 1'h0, sys_rst = 1'h1, global_enable = 1'h0;
	reg timer_a_split = 1'h0, serve = 1'h0;
	reg [25:0] irq_control_register = 26'h0, tb_clear = 26'h0, ev = 26'h0;
	reg [3:0] alt = 4'h0;
	reg [25:0] hit;
	wire [25:0] pending_flag_register, active_requests, svc_clear;
	wire irq_request, nmi_request;
	wire [4:0] irq_vector_addr, last_addr;
	integer fails = 0, checks = 0, i;
	reg [5:0] rows [0:22];

	// Design with two ports present, third absent
	ivm_mapper #(.PIN_COUNT(14)) u_dut (.mclk, .sys_rst, .global_enable,
		.timer_a_split, .irq_control_register,
		.flag_clear(tb_clear | svc_clear), .memscan_error_event(ev[1]),
		.voltage_monitor_event(ev[2]), .port_first_event(ev[3]),
		.port_second_event(ev[4]), .port_third_event(ev[5]),
		.rtc_count_event(ev[6]), .periodic_tick_event(ev[7]),
		.timer_a_overflow_event(ev[8]), .timer_a_low_underflow_event(alt[0]),
		.timer_a_high_underflow_event(ev[9]),
		.timer_a_compare_event(ev[12:10]), .timer_a_low_compare_event(alt[3:1]),
		.timer_b_capture_event(ev[13]), .comparator_event(ev[16]),
		.converter_result_event(ev[17]), .converter_window_event(ev[18]),
		.twowire_client_event(ev[19]), .twowire_host_event(ev[20]),
		.serial_periph_event(ev[21]), .serial_rx_complete_event(ev[22]),
		.serial_data_empty_event(ev[23]), .serial_tx_complete_event(ev[24]),
		.eeprom_ready_event(ev[25]), .pending_flag_register,
		.active_requests, .irq_request, .nmi_request, .irq_vector_addr);

	ivm_core_model u_core (.mclk, .sys_rst, .serve, .irq_request,
		.irq_vector_addr, .svc_clear, .last_addr);

	// Clock
	initial begin
		forever #50 mclk = ~mclk;
	end

	task tick(input integer n);
		repeat (n) @(posedge mclk);
		#5;
	endtask
	task chk_vec(input [25:0] got, input [25:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("FAIL %0t value %h exp %h", $time, got, exp);
		end
	endtask
	task chk_addr(input [4:0] got, input [4:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("FAIL %0t addr %h exp %h", $time, got, exp);
		end
	endtask
	task pulse(input [25:0] v);
		ev = v;
		tick(1);
		ev = 26'h0;
		tick(1);
	endtask
	task clear(input [25:0] v);
		tb_clear = v;
		tick(1);
		tb_clear = 26'h0;
		tick(2);
	endtask
	task summarize;
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence: table of sources, then awkward cases
	initial begin
		rows = '{6'h21, 6'h22, 6'h23, 6'h24, 6'h05, 6'h26, 6'h27, 6'h28,
			6'h09, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h30, 6'h31, 6'h32, 6'h33,
			6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39};
		tick(4);
		sys_rst = 1'h0;
		global_enable = 1'h1;
		irq_control_register = ~26'h0;
		for (i = 0; i < 23; i = i + 1) begin
			pulse(26'h1 << rows[i][4:0]);
			hit = {25'h0, rows[i][5]};
			chk_vec(pending_flag_register, hit << rows[i][4:0]);
			if (rows[i][4:0] == 5'h01)
				chk_vec(nmi_request, rows[i][5]);
			else
				chk_addr(irq_vector_addr, rows[i][5] ? rows[i][4:0] : 5'h00);
			clear(~26'h0);
		end
		global_enable = 1'h0;
		pulse(26'h4);
		chk_vec(irq_request, 26'h0);
		pulse(26'h2);
		chk_vec(nmi_request, 26'h1);
		chk_addr(irq_vector_addr, 5'h01);
		tb_clear = 26'h2;
		tick(1);
		tb_clear = 26'h0;
		global_enable = 1'h1;
		tick(2);
		chk_addr(irq_vector_addr, 5'h02);
		irq_control_register[3] = 1'h0;
		pulse(26'h8);
		chk_vec(active_requests, 26'h4);
		irq_control_register[3] = 1'h1;
		tick(20);
		chk_vec(active_requests, 26'hc);
		clear(26'h4);
		chk_addr(irq_vector_addr, 5'h03);
		ev = 26'h8;
		tb_clear = 26'h8;
		tick(1);
		ev = 26'h0;
		tb_clear = 26'h0;
		chk_vec(pending_flag_register, 26'h8);
		clear(26'h8);
		serve = 1'h1;
		pulse(26'h80040);
		for (i = 0; i < 60 && pending_flag_register !== 26'h0; i = i + 1)
			tick(1);
		if (i == 60) begin
			fails = fails + 1;
			$display("FAIL %0t service timeout", $time);
			summarize;
		end
		chk_addr(last_addr, 5'h13);
		serve = 1'h0;
		timer_a_split = 1'h1;
		pulse(26'h100);
		chk_vec(pending_flag_register, 26'h0);
		alt = 4'hf;
		pulse(26'h200);
		alt = 4'h0;
		chk_vec(pending_flag_register, 26'h1f00);
		sys_rst = 1'h1;
		tick(1);
		chk_addr(irq_vector_addr, 5'h00);
		chk_vec(pending_flag_register, 26'h0);
		sys_rst = 1'h0;
		tick(2);
		chk_vec(irq_request, 26'h0);
		chk_vec(active_requests, 26'h0);
		pulse(26'h4);
		chk_addr(irq_vector_addr, 5'h02);
		summarize;
	end
endmodule // tb_top

bind ivm_mapper ivm_mapper_monitor #(.PIN_COUNT(PIN_COUNT)) u_mon (
	.mclk(mclk), .sys_rst(sys_rst), .global_enable(global_enable),
	.irq_control_register(irq_control_register), .flag_clear(flag_clear),
	.voltage_monitor_event(voltage_monitor_event),
	.pending_flag_register(pending_flag_register),
	.active_requests(active_requests), .irq_request(irq_request),
	.nmi_request(nmi_request), .irq_vector_addr(irq_vector_addr));
